// ===== verilog/fault_status_consts.svh
// constants and register map for the fault status capture block
// Overview of operation
// - A recorded precise data bus error latches the faulting data address into bus_fault_addr_reg.
// - A precise data bus error hands back the faulting instruction address as the stacked return pc.
// - A prefetch instruction bus error sets instruction_fetch_error_flag only when that instruction issues.
// - An instruction fetch error never writes bus_fault_addr_reg.
// - mem_fault_addr_valid reads one exactly while mem_fault_addr_reg holds a valid fault address.
// - An entry stacking violation sets entry_push_violation_flag and the stack pointer is still adjusted.
// - An entry stacking violation leaves mem_fault_addr_reg unwritten.
// - An unstacking violation sets return_pop_violation_flag and keeps the return stack, with no adjust or save.
// - An unstacking violation latches no address into mem_fault_addr_reg.
// - Every flag resets to zero, is sticky, clears on a written one and ignores a written zero.
// - Reserved bits 6:5 and 2 read zero and ignore writes.
`ifndef FAULT_STATUS_CONSTS_SVH
`define FAULT_STATUS_CONSTS_SVH

// register byte offsets
`define FS_STATUS_OFF     12'h000
`define FS_BUS_ADDR_OFF   12'h004
`define FS_MEM_ADDR_OFF   12'h008
`define FS_IRQ_MASK_OFF   12'h00C
// bit positions inside the status word
`define FS_BIT_PRECISE    9
`define FS_BIT_IFETCH     8
`define FS_BIT_MADDR_VLD  7
`define FS_BIT_ENTRY_PUSH 4
`define FS_BIT_RET_POP    3
// writable flag bits; 6:5 and 2 stay out
`define FS_FLAG_MASK      32'h0000_0398
// reset values
`define FS_STATUS_RST     32'h0000_0000
`define FS_ADDR_RST       32'h0000_0000
`define FS_MASK_RST       32'h0000_0000

`endif

// ===== verilog/fault_status_pkg.sv
// types shared by the fault status capture block
package fault_status_pkg;

	// one fault report from the core, valid for one cycle
	typedef struct packed {
		logic        precise_err;
		logic [31:0] data_addr;
		logic [31:0] instr_addr;
		logic        ifetch_err;
		logic        ifetch_issue;
		logic        entry_push_viol;
		logic        return_pop_viol;
		logic        mem_viol;
		logic [31:0] mem_addr;
	} fault_event_t;

	// stacking controls sent back to the core
	typedef struct packed {
		logic        sp_adjust_en;
		logic        new_save_en;
		logic [31:0] stacked_pc;
	} stack_ctrl_t;

endpackage

// ===== verilog/fault_status_capture.sv
// sticky fault flags, fault address latches and apb access
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fault_status_consts.svh"

module fault_status_capture (
	// clock and reset
	input  wire logic                         mclk,
	input  wire logic                         rst,
	// apb slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [11:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	output logic                              pready,
	output logic                              pslverr,
	output logic      [31:0]                  prdata,
	// core fault reports
	input  wire fault_status_pkg::fault_event_t evt,
	output fault_status_pkg::stack_ctrl_t      stk,
	// interrupt
	output logic                              irq
);

	logic [31:0] flags_r;
	logic [31:0] bus_addr_r;
	logic [31:0] mem_addr_r;
	logic [31:0] mask_r;
	logic [31:0] set_nxt;
	logic [31:0] clr_nxt;
	logic        wr_acc;
	logic        rd_acc;
	logic        mapped;
	logic        ifetch_set;
	logic        mem_latch;

	// single-cycle access phase, no wait states
	assign pready  = 1'b1;
	assign wr_acc  = psel & penable & pwrite;
	assign rd_acc  = psel & penable & ~pwrite;
	assign mapped  = (paddr == `FS_STATUS_OFF) || (paddr == `FS_BUS_ADDR_OFF) ||
		(paddr == `FS_MEM_ADDR_OFF) || (paddr == `FS_IRQ_MASK_OFF);
	assign pslverr = psel & penable & ~mapped;

	// discarded prefetches never reach the flag
	assign ifetch_set = evt.ifetch_err & evt.ifetch_issue;
	// stacking violations do not qualify for an address capture
	assign mem_latch  = evt.mem_viol & ~evt.entry_push_viol & ~evt.return_pop_viol;

	// hardware set terms
	always_comb begin
		set_nxt = 32'h0000_0000;
		set_nxt[`FS_BIT_PRECISE]    = evt.precise_err;
		set_nxt[`FS_BIT_IFETCH]     = ifetch_set;
		set_nxt[`FS_BIT_MADDR_VLD]  = mem_latch;
		set_nxt[`FS_BIT_ENTRY_PUSH] = evt.entry_push_viol;
		set_nxt[`FS_BIT_RET_POP]    = evt.return_pop_viol;
	end

	// write-one clear, confined to real flag bits
	assign clr_nxt = (wr_acc && paddr == `FS_STATUS_OFF) ? (pwdata & `FS_FLAG_MASK)
		: 32'h0000_0000;

	// sticky flags; set wins so a coinciding event is never lost
	always_ff @(posedge mclk) begin
		if (rst) begin
			flags_r <= `FS_STATUS_RST;
		end else begin
			flags_r <= ((flags_r & ~clr_nxt) | set_nxt) & `FS_FLAG_MASK;
		end
	end

	// bus fault address; only precise errors carry a usable address
	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_addr_r <= `FS_ADDR_RST;
		end else if (evt.precise_err) begin
			bus_addr_r <= evt.data_addr;
		end
	end

	// memory fault address, paired with the valid flag
	always_ff @(posedge mclk) begin
		if (rst) begin
			mem_addr_r <= `FS_ADDR_RST;
		end else if (mem_latch) begin
			mem_addr_r <= evt.mem_addr;
		end
	end

	// interrupt mask
	always_ff @(posedge mclk) begin
		if (rst) begin
			mask_r <= `FS_MASK_RST;
		end else if (wr_acc && paddr == `FS_IRQ_MASK_OFF) begin
			mask_r <= pwdata & `FS_FLAG_MASK;
		end
	end

	// read data registered at the setup edge; unmapped reads give zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			if (paddr == `FS_STATUS_OFF) begin
				prdata <= flags_r;
			end else if (paddr == `FS_BUS_ADDR_OFF) begin
				prdata <= bus_addr_r;
			end else if (paddr == `FS_MEM_ADDR_OFF) begin
				prdata <= mem_addr_r;
			end else if (paddr == `FS_IRQ_MASK_OFF) begin
				prdata <= mask_r;
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// stacking control; unstack fault keeps the old frame in place
	always_ff @(posedge mclk) begin
		if (rst) begin
			stk <= '0;
		end else begin
			stk.sp_adjust_en <= ~evt.return_pop_viol;
			stk.new_save_en  <= ~evt.return_pop_viol;
			stk.stacked_pc   <= evt.instr_addr;
		end
	end

	// level interrupt
	assign irq = |(flags_r & mask_r);

	// flag set one cycle after its event
	precise_set_a: assert property (@(posedge mclk) disable iff (rst)
		evt.precise_err |=> flags_r[`FS_BIT_PRECISE] && bus_addr_r == $past(evt.data_addr))
		else $error("precise error not captured");
	stacked_pc_a: assert property (@(posedge mclk) disable iff (rst)
		evt.precise_err |=> stk.stacked_pc == $past(evt.instr_addr))
		else $error("stacked pc mismatch");
	ifetch_gate_a: assert property (@(posedge mclk) disable iff (rst)
		!flags_r[`FS_BIT_IFETCH] && !(evt.ifetch_err && evt.ifetch_issue)
		|=> !flags_r[`FS_BIT_IFETCH])
		else $error("fetch flag set without issue");
	ifetch_noaddr_a: assert property (@(posedge mclk) disable iff (rst)
		!evt.precise_err |=> $stable(bus_addr_r))
		else $error("bus address written without precise error");
	valid_pair_a: assert property (@(posedge mclk) disable iff (rst)
		mem_latch |=> flags_r[`FS_BIT_MADDR_VLD] && mem_addr_r == $past(evt.mem_addr))
		else $error("mem address valid mismatch");
	entry_push_a: assert property (@(posedge mclk) disable iff (rst)
		evt.entry_push_viol |=> flags_r[`FS_BIT_ENTRY_PUSH] && stk.sp_adjust_en
		|| $past(evt.return_pop_viol))
		else $error("entry push flag missing");
	entry_noaddr_a: assert property (@(posedge mclk) disable iff (rst)
		evt.entry_push_viol |=> $stable(mem_addr_r))
		else $error("mem address written on entry push");
	return_pop_a: assert property (@(posedge mclk) disable iff (rst)
		evt.return_pop_viol |=> flags_r[`FS_BIT_RET_POP] && !stk.sp_adjust_en
		&& !stk.new_save_en && $stable(mem_addr_r))
		else $error("return pop handling wrong");
	w1c_clear_a: assert property (@(posedge mclk) disable iff (rst)
		wr_acc && paddr == `FS_STATUS_OFF && pwdata[`FS_BIT_RET_POP] && !evt.return_pop_viol
		|=> !flags_r[`FS_BIT_RET_POP])
		else $error("write one did not clear");
	w0_keep_a: assert property (@(posedge mclk) disable iff (rst)
		flags_r[`FS_BIT_PRECISE] && !(wr_acc && paddr == `FS_STATUS_OFF
		&& pwdata[`FS_BIT_PRECISE]) |=> flags_r[`FS_BIT_PRECISE])
		else $error("flag lost without write one");
	reserved_zero_a: assert property (@(posedge mclk) disable iff (rst)
		flags_r[6:5] == 2'h0 && flags_r[2] == 1'b0)
		else $error("reserved bits not zero");
	set_wins_a: assert property (@(posedge mclk) disable iff (rst)
		evt.entry_push_viol && wr_acc && paddr == `FS_STATUS_OFF
		|=> flags_r[`FS_BIT_ENTRY_PUSH])
		else $error("clear beat set");
	irq_level_a: assert property (@(posedge mclk) disable iff (rst)
		irq == |(flags_r & mask_r))
		else $error("irq level wrong");

	// bus handshake: never a wait state, error only off the map
	pready_high_a: assert property (@(posedge mclk) disable iff (rst)
		pready)
		else $error("pready dropped");
	// unmapped access must flag an error
	slverr_unmap_a: assert property (@(posedge mclk) disable iff (rst)
		psel && penable && !mapped |-> pslverr)
		else $error("unmapped access without error");
	// mapped access must not flag an error
	slverr_map_a: assert property (@(posedge mclk) disable iff (rst)
		psel && penable && mapped |-> !pslverr)
		else $error("mapped access flagged error");

	// read data loaded at the setup edge, one check per register
	rd_status_a: assert property (@(posedge mclk) disable iff (rst)
		psel && !penable && !pwrite && paddr == `FS_STATUS_OFF |=> prdata == $past(flags_r))
		else $error("status read wrong");
	rd_bus_addr_a: assert property (@(posedge mclk) disable iff (rst)
		psel && !penable && !pwrite && paddr == `FS_BUS_ADDR_OFF |=> prdata == $past(bus_addr_r))
		else $error("bus address read wrong");
	rd_mem_addr_a: assert property (@(posedge mclk) disable iff (rst)
		psel && !penable && !pwrite && paddr == `FS_MEM_ADDR_OFF |=> prdata == $past(mem_addr_r))
		else $error("mem address read wrong");
	rd_mask_a: assert property (@(posedge mclk) disable iff (rst)
		psel && !penable && !pwrite && paddr == `FS_IRQ_MASK_OFF |=> prdata == $past(mask_r))
		else $error("mask read wrong");
	// reads off the map must not leak stale data
	rd_unmapped_a: assert property (@(posedge mclk) disable iff (rst)
		psel && !penable && !pwrite && !mapped |=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// mask register takes only flag positions
	mask_write_a: assert property (@(posedge mclk) disable iff (rst)
		wr_acc && paddr == `FS_IRQ_MASK_OFF |=> mask_r == ($past(pwdata) & `FS_FLAG_MASK))
		else $error("mask write wrong");
	// mask changes only on its own write
	mask_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!(wr_acc && paddr == `FS_IRQ_MASK_OFF) |=> $stable(mask_r))
		else $error("mask changed without write");
	// mask keeps the status layout
	mask_layout_a: assert property (@(posedge mclk) disable iff (rst)
		(mask_r & ~`FS_FLAG_MASK) == 32'h0000_0000)
		else $error("mask holds non-flag bits");

	// software cannot overwrite the bus fault address
	bus_addr_ro_a: assert property (@(posedge mclk) disable iff (rst)
		wr_acc && paddr == `FS_BUS_ADDR_OFF && !evt.precise_err |=> $stable(bus_addr_r))
		else $error("bus address written by software");
	// a fetch error alone leaves the bus fault address alone
	ifetch_keep_a: assert property (@(posedge mclk) disable iff (rst)
		evt.ifetch_err && !evt.precise_err |=> $stable(bus_addr_r))
		else $error("fetch error wrote bus address");
	// memory address moves only together with its valid flag
	mem_addr_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!mem_latch |=> $stable(mem_addr_r))
		else $error("mem address moved without capture");

	// no flag rises without its own event
	valid_only_a: assert property (@(posedge mclk) disable iff (rst)
		!mem_latch && !flags_r[`FS_BIT_MADDR_VLD] |=> !flags_r[`FS_BIT_MADDR_VLD])
		else $error("valid flag set without capture");
	push_only_a: assert property (@(posedge mclk) disable iff (rst)
		!evt.entry_push_viol && !flags_r[`FS_BIT_ENTRY_PUSH] |=> !flags_r[`FS_BIT_ENTRY_PUSH])
		else $error("push flag set without event");
	pop_only_a: assert property (@(posedge mclk) disable iff (rst)
		!evt.return_pop_viol && !flags_r[`FS_BIT_RET_POP] |=> !flags_r[`FS_BIT_RET_POP])
		else $error("pop flag set without event");
	precise_only_a: assert property (@(posedge mclk) disable iff (rst)
		!evt.precise_err && !flags_r[`FS_BIT_PRECISE] |=> !flags_r[`FS_BIT_PRECISE])
		else $error("precise flag set without event");
	// an issued faulting fetch must leave its mark
	ifetch_set_a: assert property (@(posedge mclk) disable iff (rst)
		evt.ifetch_err && evt.ifetch_issue |=> flags_r[`FS_BIT_IFETCH])
		else $error("issued fetch error not flagged");

	// stacking stays enabled unless an unstack fault was seen
	stk_normal_a: assert property (@(posedge mclk) disable iff (rst)
		!evt.return_pop_viol |=> stk.sp_adjust_en && stk.new_save_en)
		else $error("stacking blocked without pop fault");
	// only flag positions can ever read one
	non_flag_zero_a: assert property (@(posedge mclk) disable iff (rst)
		(flags_r & ~`FS_FLAG_MASK) == 32'h0000_0000)
		else $error("non-flag bit set");
	// a quiet write-one clears every named flag
	w1c_all_a: assert property (@(posedge mclk) disable iff (rst)
		wr_acc && paddr == `FS_STATUS_OFF && set_nxt == 32'h0000_0000
		|=> (flags_r & $past(pwdata) & `FS_FLAG_MASK) == 32'h0000_0000)
		else $error("write one left a flag set");
	// an interrupt needs a flag behind it
	irq_cause_a: assert property (@(posedge mclk) disable iff (rst)
		irq |-> |flags_r)
		else $error("irq without flag");

	// reset clears flags, mask and stacking controls
	reset_flags_a: assert property (@(posedge mclk)
		rst |=> flags_r == 32'h0000_0000 && mask_r == 32'h0000_0000)
		else $error("reset left state");
	reset_stk_a: assert property (@(posedge mclk)
		rst |=> stk == '0)
		else $error("reset left stacking controls");

	precise_seen_c: cover property (@(posedge mclk) disable iff (rst) evt.precise_err);
	ifetch_drop_c: cover property (@(posedge mclk) disable iff (rst)
		evt.ifetch_err && !evt.ifetch_issue);
	pop_viol_c: cover property (@(posedge mclk) disable iff (rst) evt.return_pop_viol);
	set_clear_c: cover property (@(posedge mclk) disable iff (rst)
		|set_nxt && |clr_nxt);
	// unmasked flag raising the interrupt
	irq_raised_c: cover property (@(posedge mclk) disable iff (rst) irq);

endmodule

// ===== bench/core_model.sv
// behavioural core that reports fault events to the capture block
`timescale 1ns/1ps

module core_model (
	// clock
	input  wire logic                           mclk,
	// command from the bench
	input  wire logic                           go,
	input  wire fault_status_pkg::fault_event_t req,
	// fault report to the block
	output fault_status_pkg::fault_event_t      evt
);
	// one-cycle pulse; addresses scramble between reports so stale data is never trusted
	initial evt = 0;
	always @(posedge mclk) evt <= go ? req : {1'b0, ~evt.data_addr, ~evt.instr_addr, 5'h00,
		~evt.mem_addr};
endmodule

// ===== bench/test_fault_status_capture.sv
// self-checking bench for the fault status capture block
`timescale 1ns/1ps

module test_fault_status_capture;
	// design and model hookup
	logic                           mclk, rst, psel, penable, pwrite, pready, pslverr, irq, go, er;
	logic [11:0]                    paddr;
	logic [31:0]                    pwdata, prdata, rd;
	int                             num_errors, checks_done;
	fault_status_pkg::fault_event_t evt, req;
	fault_status_pkg::stack_ctrl_t  stk, seen;

	fault_status_capture fault_status_capture_inst (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .evt(evt), .stk(stk), .irq(irq));
	core_model core_model_inst (.mclk(mclk), .go(go), .req(req), .evt(evt));

	// 250 MHz core clock
	always #2 mclk = ~mclk;

	task give_verdict;
		if (num_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one apb transfer; a hung slave ends the run
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next call never re-raises psel in this time step
		@(posedge mclk);
		if (pready !== 1'b1) begin
			num_errors++;
			give_verdict;
		end
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask

	// fault report, k = {precise, fetch, issue, push, pop, mem}
	task ev(input logic [5:0] k, input logic [31:0] a);
		req <= '{k[5], a, 32'h0000_0ABC, k[4], k[3], k[2], k[1], k[0], a};
		go  <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		// stacking controls stand for one cycle only; take them mid-cycle
		@(negedge mclk);
		seen = stk;
		@(posedge mclk);
	endtask

	task s_reset;
		rdc(12'h000, 32'h0000_0000);
		rdc(12'h00C, 32'h0000_0000);
	endtask

	task s_bus;
		ev(6'h20, 32'h1234_5678);
		chk(seen.stacked_pc, 32'h0000_0ABC);
		rdc(12'h000, 32'h0000_0200);
		rdc(12'h004, 32'h1234_5678);
		apb(1'b1, 12'h004, 32'h0000_0000);
		rdc(12'h004, 32'h1234_5678);
	endtask

	task s_fetch;
		ev(6'h10, 32'h0000_BEEF);
		rdc(12'h000, 32'h0000_0200);
		ev(6'h18, 32'h0000_BEEF);
		rdc(12'h000, 32'h0000_0300);
		rdc(12'h004, 32'h1234_5678);
	endtask

	task s_mem;
		ev(6'h01, 32'h0000_1000);
		rdc(12'h008, 32'h0000_1000);
		ev(6'h05, 32'h0000_2000);
		chk({31'h0, seen.sp_adjust_en}, 32'h1);
		rdc(12'h008, 32'h0000_1000);
		ev(6'h03, 32'h0000_3000);
		chk({30'h0, seen.sp_adjust_en, seen.new_save_en}, 32'h0);
		rdc(12'h008, 32'h0000_1000);
		rdc(12'h000, 32'h0000_0398);
	endtask

	task s_clear;
		apb(1'b1, 12'h000, 32'h0000_0000);
		rdc(12'h000, 32'h0000_0398);
		apb(1'b1, 12'h000, 32'hFFFF_FC67);
		rdc(12'h000, 32'h0000_0398);
		apb(1'b1, 12'h000, 32'h0000_0088);
		rdc(12'h000, 32'h0000_0310);
	endtask

	task s_irq;
		apb(1'b1, 12'h00C, 32'h0000_0010);
		rdc(12'h00C, 32'h0000_0010);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 12'h000, 32'h0000_0010);
		chk({31'h0, irq}, 32'h0);
	endtask

	// event and its clearing write land on the same edge
	task s_coin;
		fork
			ev(6'h20, 32'h0000_4444);
			apb(1'b1, 12'h000, 32'h0000_0300);
		join
		rdc(12'h000, 32'h0000_0200);
		rdc(12'h010, 32'h0000_0000);
		chk({31'h0, er}, 32'h1);
	endtask

	// reset, then every scenario in turn
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, go, req} = 0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		s_reset;
		s_bus;
		s_fetch;
		s_mem;
		s_clear;
		s_irq;
		s_coin;
		give_verdict;
	end
endmodule
